// ===== shared/dscc_pkg.sv
// Purpose: constants shared by the dma status / crc control block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   all control bits reset to zero
`default_nettype none
package dscc_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_STAT = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_DATA = 12'h00C;
  localparam logic [11:0] OFS_XOR  = 12'h010;
  // field positions in the status register
  localparam int DIR_BIT = 3;
  localparam int CHN_LSB = 0;
  // field positions in the crc control register
  localparam int BYTE_ORDER_SELECTOR_LSB = 28;
  localparam int WBO_BIT  = 27;
  localparam int BIT_ORDER_BIT_BIT = 24;
  localparam int POLYNOMIAL_LENGTH_FIELD_LSB = 8;
  localparam int EN_BIT   = 7;
  localparam int APP_BIT  = 6;
  localparam int TYP_BIT  = 5;
  localparam int CSEL_LSB = 0;
  // writable bits of the control register
  localparam logic [31:0] CTRL_WMASK = 32'h3900_1FE7;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  // byte order selector codes
  localparam logic [1:0] BO_NONE = 2'h0;
  localparam logic [1:0] BO_WORD = 2'h1;
  localparam logic [1:0] BO_HALF = 2'h2;
  localparam logic [1:0] BO_HSWP = 2'h3;
  // highest legal channel code
  localparam logic [2:0] CH_MAX = 3'h3;
  // answer latency of the apb slave in cycles after the setup phase
  localparam int APB_WAIT = 1;
endpackage
`default_nettype wire

// ===== hw/dscc_top.sv
// Purpose: dma last-access status and crc engine control with apb access
// Assumes: access monitor and channel stream run on pclk
// Notes:   two-entry skid buffer sits in the destination data path
`timescale 1ns/1ps
`default_nettype none
module dscc_top
  import dscc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        acc_valid,
  input  wire logic        acc_read,
  input  wire logic [2:0]  acc_chan,
  input  wire logic [31:0] acc_addr,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [2:0]  in_chan,
  input  wire logic [31:0] in_data,
  input  wire logic [31:0] in_addr,
  input  wire logic        blk_done,
  input  wire logic [31:0] dest_start,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [31:0]      out_data,
  output logic [31:0]      out_addr,
  output logic             out_is_crc
);

  // reorder bytes of one word
  function automatic logic [31:0] reorder(input logic [31:0] d, input logic [1:0] s);
    unique case (s)
      BO_NONE: reorder = d;
      BO_WORD: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
      BO_HALF: reorder = {d[15:0], d[31:16]};
      BO_HSWP: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
    endcase
  endfunction

  // ones above the polynomial length read zero
  function automatic logic [31:0] lmask(input logic [4:0] pl);
    lmask = 32'hFFFF_FFFF >> (5'd31 - pl);
  endfunction

  // one word through the shift-register crc, msb or lsb first
  function automatic logic [31:0] lfsr_word(input logic [31:0] c, input logic [31:0] x,
                                            input logic [4:0] pl, input logic [31:0] d,
                                            input logic bo);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 32; i++) begin
      fb = r[pl] ^ (bo ? d[i] : d[31-i]);
      r  = r << 1;
      if (fb) begin
        r = r ^ x;
      end
      r = r & lmask(pl);
    end
    lfsr_word = r;
  endfunction

  // reverse the bits of a half-word
  function automatic logic [15:0] rev16(input logic [15:0] h);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = h[15-i];
    end
  endfunction

  // ones complement add of both half-words
  function automatic logic [15:0] ip_word(input logic [15:0] s, input logic [31:0] d, input logic bo);
    logic [15:0] h1;
    logic [15:0] h0;
    logic [16:0] t;
    h1 = bo ? rev16(d[31:16]) : d[31:16];
    h0 = bo ? rev16(d[15:0]) : d[15:0];
    t  = {1'b0, s} + {1'b0, h1};
    t  = {1'b0, t[15:0]} + {16'h0000, t[16]};
    t  = {1'b0, t[15:0]} + {1'b0, h0};
    t  = {1'b0, t[15:0]} + {16'h0000, t[16]};
    ip_word = t[15:0];
  endfunction

  logic        dir_q;
  logic [2:0]  chan_q;
  logic [31:0] laddr_q;
  logic [31:0] ctrl_q;
  logic [31:0] xor_q;
  logic [31:0] crc_q;
  logic [15:0] ip_q;
  logic        app_pend_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        rdy_q;
  logic        ov_q;
  logic [64:0] ob_q;
  logic        sv_q;
  logic [64:0] sb_q;
  logic        sv_d;

  // control field decode
  wire logic [1:0] byte_order_selector = ctrl_q[BYTE_ORDER_SELECTOR_LSB +: 2];
  wire logic       write_order_bit  = ctrl_q[WBO_BIT];
  wire logic       bit_order_bit = ctrl_q[BIT_ORDER_BIT_BIT];
  wire logic [4:0] polynomial_length_field = ctrl_q[POLYNOMIAL_LENGTH_FIELD_LSB +: 5];
  wire logic       cen  = ctrl_q[EN_BIT];
  wire logic       capp = ctrl_q[APP_BIT];
  wire logic       ctyp = ctrl_q[TYP_BIT];
  wire logic [2:0] csel = ctrl_q[CSEL_LSB +: 3];

  // apb decode, setup phase and access phase
  wire logic setup  = psel & ~penable;
  wire logic wr_go  = psel & penable & pready_q & pwrite;
  wire logic hit_st = paddr == OFS_STAT;
  wire logic hit_ad = paddr == OFS_ADDR;
  wire logic hit_cc = paddr == OFS_CTRL;
  wire logic hit_dt = paddr == OFS_DATA;
  wire logic hit_xr = paddr == OFS_XOR;
  wire logic mapped = hit_st | hit_ad | hit_cc | hit_dt | hit_xr;

  // crc value as read by software and appended
  wire logic [31:0] crc_rd = ctyp ? {16'h0000, ~ip_q} : (crc_q & lmask(polynomial_length_field));

  // read mux with unimplemented bits at zero
  wire logic [31:0] rd_mux =
      hit_st ? {28'h000_0000, dir_q, chan_q} :
      hit_ad ? laddr_q :
      hit_cc ? ctrl_q :
      hit_dt ? crc_rd :
      hit_xr ? xor_q : ZERO32;

  // control write with append refused under write order
  wire logic [31:0] cwr   = pwdata & CTRL_WMASK;
  wire logic        app_w = cwr[APP_BIT] & ~cwr[WBO_BIT] & ~write_order_bit;
  wire logic [31:0] ctrl_d = {cwr[31:APP_BIT+1], app_w, cwr[APP_BIT-1:0]};

  // stream side: engine hit for the selected legal channel
  wire logic acc_w  = in_valid & rdy_q;
  wire logic sel_ok = csel <= CH_MAX;
  wire logic hit    = cen & sel_ok & (in_chan == csel);
  wire logic eng_go = acc_w & hit;
  wire logic drop   = hit & capp;
  wire logic [31:0] ro_dat = reorder(in_data, byte_order_selector);
  wire logic [31:0] dst_dat = (hit & write_order_bit) ? ro_dat : in_data;
  wire logic app_go = app_pend_q & ~acc_w & rdy_q;
  wire logic push   = (acc_w & ~drop) | app_go;
  wire logic [64:0] pd = app_go ? {1'b1, dest_start, crc_rd} : {1'b0, in_addr, dst_dat};
  wire logic pop    = ov_q & out_ready;
  wire logic seed   = wr_go & hit_dt;

  // last dma access status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q   <= 1'b0;
      chan_q  <= 3'h0;
      laddr_q <= ZERO32;
    end else if (acc_valid) begin
      dir_q   <= acc_read;
      chan_q  <= acc_chan;
      laddr_q <= acc_addr;
    end
  end

  // apb answer registered at the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= ZERO32;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= (setup & ~pwrite) ? rd_mux : ZERO32;
    end
  end

  // control and polynomial registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      xor_q  <= ZERO32;
    end else if (wr_go) begin
      if (hit_cc) begin
        ctrl_q <= ctrl_d;
      end
      if (hit_xr) begin
        xor_q <= pwdata;
      end
    end
  end

  // crc engine: seed by write, advance on each routed word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= ZERO32;
      ip_q  <= 16'h0000;
    end else if (seed) begin
      crc_q <= pwdata & lmask(polynomial_length_field);
      ip_q  <= ~pwdata[15:0];
    end else if (eng_go) begin
      if (ctyp) begin
        ip_q <= ip_word(ip_q, ro_dat, bit_order_bit);
      end else begin
        crc_q <= lfsr_word(crc_q, xor_q, polynomial_length_field, ro_dat, bit_order_bit);
      end
    end
  end

  // append request waits for a free buffer slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_pend_q <= 1'b0;
    end else if (blk_done & cen & capp & sel_ok) begin
      app_pend_q <= 1'b1;
    end else if (app_go) begin
      app_pend_q <= 1'b0;
    end
  end

  // skid slot fills only when the output stalls
  always_comb begin
    sv_d = sv_q;
    if (pop | ~ov_q) begin
      sv_d = sv_q & push;
    end else if (push) begin
      sv_d = 1'b1;
    end
  end

  // two-entry buffer: output word plus skid word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q  <= 1'b0;
      ob_q  <= 65'h0;
      sv_q  <= 1'b0;
      sb_q  <= 65'h0;
      rdy_q <= 1'b0;
    end else begin
      sv_q  <= sv_d;
      rdy_q <= ~sv_d;
      if (pop | ~ov_q) begin
        ov_q <= sv_q | push;
        ob_q <= sv_q ? sb_q : pd;
        if (sv_q) begin
          sb_q <= pd;
        end
      end else if (push) begin
        sb_q <= pd;
      end
    end
  end

  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign prdata     = prdata_q;
  assign in_ready   = rdy_q;
  assign out_valid  = ov_q;
  assign out_is_crc = ob_q[64];
  assign out_addr   = ob_q[63:32];
  assign out_data   = ob_q[31:0];

  // checks on the status capture
  a_dir_follows_acc: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid |=> dir_q == $past(acc_read)) else $error("direction bit wrong");
  a_chan_follows_acc: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid |=> chan_q == $past(acc_chan)) else $error("channel field wrong");
  a_addr_follows_acc: assert property (@(posedge pclk) disable iff (!presetn)
    acc_valid |=> laddr_q == $past(acc_addr)) else $error("last address wrong");
  a_status_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !acc_valid |=> $stable(laddr_q) && $stable(dir_q) && $stable(chan_q)) else $error("status moved idle");
  // checks on control and engine
  a_app_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[WBO_BIT] |-> !ctrl_q[APP_BIT]) else $error("append set with write order");
  a_engine_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !eng_go && !seed |=> $stable(crc_q) && $stable(ip_q)) else $error("crc moved unrouted");
  a_drop_append: assert property (@(posedge pclk) disable iff (!presetn)
    acc_w && hit && capp && !ov_q |=> !ov_q || ob_q[64]) else $error("append data reached destination");
  // checks on register reads
  a_data_masked: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && hit_dt && !ctyp && $stable(polynomial_length_field)
      |-> (prdata_q & ~lmask(polynomial_length_field)) == ZERO32) else $error("crc bits above length");
  a_stat_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && hit_st |-> prdata_q[31:4] == 28'h000_0000) else $error("status upper bits set");
  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready_q) else $error("apb answer late");

endmodule // dscc_top
`default_nettype wire

// ===== bench/dscc_chan_model.sv
// Purpose: dma channel side: access pulses, source words, destination sink
// Assumes: one clock, every line changes just after a rising edge
// Notes:   released lines show the inverse of their last value, except dest_start, which keeps its value
`timescale 1ns/1ps
`default_nettype none
module dscc_chan_model (
  input  wire logic        pclk,
  output logic             acc_valid,
  output logic             acc_read,
  output logic [2:0]       acc_chan,
  output logic [31:0]      acc_addr,
  output logic             in_valid,
  input  wire logic        in_ready,
  output logic [2:0]       in_chan,
  output logic [31:0]      in_data,
  output logic [31:0]      in_addr,
  output logic             blk_done,
  output logic [31:0]      dest_start,
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [31:0] out_data,
  input  wire logic [31:0] out_addr,
  input  wire logic        out_is_crc
);
  logic        stall;
  logic [31:0] got_d[$];
  logic [31:0] got_a[$];
  logic        got_c[$];
  // quiet lines at time zero
  initial begin
    {acc_valid, acc_read, acc_chan, in_valid, in_chan, blk_done, out_ready, stall} = '0;
    {acc_addr, in_data, in_addr, dest_start} = '0;
  end
  // one pulse per bus access
  task automatic access(input logic rd, input logic [2:0] ch, input logic [31:0] a);
    @(posedge pclk);
    {acc_valid, acc_read, acc_chan, acc_addr} <= {1'b1, rd, ch, a};
    @(posedge pclk);
    {acc_valid, acc_read, acc_chan, acc_addr} <= {1'b0, ~rd, ~ch, ~a};
  endtask
  // one source word, held until taken
  task automatic send(input logic [2:0] ch, input logic [31:0] d, input logic [31:0] a);
    @(posedge pclk);
    {in_valid, in_chan, in_data, in_addr} <= {1'b1, ch, d, a};
    @(posedge pclk);
    while (in_ready !== 1'b1) @(posedge pclk);
    {in_valid, in_chan, in_data, in_addr} <= {1'b0, ~ch, ~d, ~a};
  endtask
  // end of block pulse
  task automatic done(input logic [31:0] a);
    @(posedge pclk);
    {blk_done, dest_start} <= {1'b1, a};
    @(posedge pclk);
    blk_done <= 1'b0;
  endtask
  // sink collects every handed word, stalls on request
  always @(posedge pclk) begin
    out_ready <= !stall;
    if (out_valid && out_ready) begin
      got_d.push_back(out_data);
      got_a.push_back(out_addr);
      got_c.push_back(out_is_crc);
    end
  end
endmodule // dscc_chan_model
`default_nettype wire

// ===== bench/dma_status_crc_control_bench.sv
// Purpose: self-checking bench for the dma status and crc control block
// Assumes: apb master waits for pready, channel model drives the dma side
// Notes:   no random stimulus, a cycle ceiling cuts a hang short
`timescale 1ns/1ps
`default_nettype none
module dma_status_crc_control_bench import dscc_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        acc_valid, acc_read, in_valid, in_ready, blk_done, out_valid, out_ready, out_is_crc;
  logic [2:0]  acc_chan, in_chan;
  logic [31:0] acc_addr, in_data, in_addr, dest_start, out_data, out_addr;
  int          n_fail, checks_done, n;
  localparam logic [31:0] BO_EXP [4] = '{32'h1122_3344, 32'h4433_2211, 32'h3344_1122, 32'h2211_4433};
  dscc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_read(acc_read), .acc_chan(acc_chan), .acc_addr(acc_addr),
    .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan), .in_data(in_data), .in_addr(in_addr),
    .blk_done(blk_done), .dest_start(dest_start), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_addr(out_addr), .out_is_crc(out_is_crc));
  dscc_chan_model i_chan (.pclk(pclk), .acc_valid(acc_valid), .acc_read(acc_read), .acc_chan(acc_chan),
    .acc_addr(acc_addr), .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan), .in_data(in_data),
    .in_addr(in_addr), .blk_done(blk_done), .dest_start(dest_start), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_addr(out_addr), .out_is_crc(out_is_crc));
  // 250 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, ZERO32);
    chk(rd, exp);
  endtask
  task automatic clr();
    i_chan.got_d.delete();
    i_chan.got_a.delete();
    i_chan.got_c.delete();
  endtask
  task automatic wait_out(input int k);
    while (i_chan.got_d.size() < k) @(posedge pclk);
  endtask
  // one word through the stream, compare what leaves
  task automatic pass_word(input logic [2:0] ch, input logic [31:0] exp);
    clr();
    i_chan.send(ch, 32'h1122_3344, 32'h0000_0100);
    wait_out(1);
    chk(i_chan.got_d[0], exp);
    chk(i_chan.got_a[0], 32'h0000_0100);
    chk(32'(i_chan.got_c[0]), ZERO32);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cycle ceiling against hangs
  initial begin
    repeat (6000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_STAT, ZERO32);
    rdc(OFS_ADDR, ZERO32);
    rdc(OFS_CTRL, ZERO32);
    rdc(12'h014, ZERO32);
    chk(32'(err), 32'h0000_0001);
    i_chan.access(1'b1, 3'h5, 32'hCAFE_0010);
    rdc(OFS_STAT, 32'h0000_000D);
    rdc(OFS_ADDR, 32'hCAFE_0010);
    i_chan.access(1'b0, 3'h2, 32'h0000_0404);
    apb(1'b1, OFS_STAT, 32'hFFFF_FFFF);
    rdc(OFS_STAT, 32'h0000_0002);
    rdc(OFS_ADDR, 32'h0000_0404);
    apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
    rdc(OFS_CTRL, 32'h3900_1FA7);
    apb(1'b1, OFS_CTRL, 32'h0000_00C0);
    rdc(OFS_CTRL, 32'h0000_0080);
    apb(1'b1, OFS_CTRL, 32'h0000_00C0);
    rdc(OFS_CTRL, 32'h0000_00C0);
    apb(1'b1, OFS_CTRL, 32'h0000_0700);
    apb(1'b1, OFS_DATA, 32'hFFFF_FFFF);
    rdc(OFS_DATA, 32'h0000_00FF);
    apb(1'b1, OFS_CTRL, 32'h0000_0720);
    apb(1'b1, OFS_DATA, 32'hABCD_1234);
    rdc(OFS_DATA, 32'h0000_1234);
    // every byte order code on the highest channel
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, OFS_CTRL, 32'h0800_0083 | (32'(b) << BYTE_ORDER_SELECTOR_LSB));
      pass_word(3'h3, BO_EXP[b]);
    end
    apb(1'b1, OFS_CTRL, 32'h1000_0083);
    pass_word(3'h3, 32'h1122_3344);
    apb(1'b1, OFS_CTRL, 32'h1800_0003);
    pass_word(3'h3, 32'h1122_3344);
    apb(1'b1, OFS_CTRL, 32'h1800_0084);
    pass_word(3'h4, 32'h1122_3344);
    // bit order in both engine modes, one seeded word each
    apb(1'b1, OFS_XOR, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0783);
    apb(1'b1, OFS_DATA, ZERO32);
    pass_word(3'h3, 32'h1122_3344);
    rdc(OFS_DATA, 32'h0000_0044);
    apb(1'b1, OFS_CTRL, 32'h0100_0783);
    apb(1'b1, OFS_DATA, ZERO32);
    pass_word(3'h3, 32'h1122_3344);
    rdc(OFS_DATA, 32'h0000_0022);
    apb(1'b1, OFS_CTRL, 32'h0000_00A3);
    apb(1'b1, OFS_DATA, 32'h0000_FFFF);
    pass_word(3'h3, 32'h1122_3344);
    rdc(OFS_DATA, 32'h0000_BB99);
    apb(1'b1, OFS_CTRL, 32'h0100_00A3);
    apb(1'b1, OFS_DATA, 32'h0000_FFFF);
    pass_word(3'h3, 32'h1122_3344);
    rdc(OFS_DATA, 32'h0000_98AB);
    // append: word swallowed, crc word at block end
    apb(1'b1, OFS_CTRL, 32'h0000_00C1);
    apb(1'b1, OFS_DATA, 32'h0000_0001);
    clr();
    i_chan.send(3'h1, 32'h5555_AAAA, 32'h0000_0200);
    repeat (4) @(posedge pclk);
    chk(32'(i_chan.got_d.size()), ZERO32);
    i_chan.done(32'h0000_0800);
    wait_out(1);
    chk(i_chan.got_a[0], 32'h0000_0800);
    chk(32'(i_chan.got_c[0]), 32'h0000_0001);
    chk(i_chan.got_d[0], 32'h0000_0001);
    // fill the buffer while the sink stalls, then drain
    apb(1'b1, OFS_CTRL, ZERO32);
    clr();
    i_chan.stall = 1'b1;
    repeat (2) @(posedge pclk);
    n = 0;
    for (int k = 0; k < 6; k++) begin
      @(negedge pclk);
      if (in_ready !== 1'b1) break;
      i_chan.send(3'h2, 32'hB000_0000 + k, 32'h0000_0300);
      n++;
    end
    chk(32'(in_ready), ZERO32);
    chk(32'(n >= 2), 32'h0000_0001);
    i_chan.stall = 1'b0;
    wait_out(n);
    for (int k = 0; k < n; k++) chk(i_chan.got_d[k], 32'hB000_0000 + k);
    // reset in mid-run clears the captured status
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_STAT, ZERO32);
    rdc(OFS_ADDR, ZERO32);
    give_verdict();
  end
endmodule // dma_status_crc_control_bench
`default_nettype wire
